// ### eir_pkg.sv
// Purpose: Shared constants for the end-of-conversion interrupt block.
// Assumes: APB byte addresses, one 32-bit word per register.
// Notes: Field positions refer to the configuration word.
package eir_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] EIR_A_CFG = 8'h00;
  localparam logic [7:0] EIR_A_HIGH = 8'h04;
  localparam logic [7:0] EIR_A_LOW = 8'h08;
  localparam logic [7:0] EIR_A_STS = 8'h0c;
  localparam logic [7:0] EIR_A_MASK = 8'h10;
  localparam logic [7:0] EIR_A_RES = 8'h14;

  // ****************************************
  // Configuration fields
  // ****************************************
  localparam int EIR_F_MODE = 0;
  localparam int EIR_F_LATCH = 2;
  localparam int EIR_F_SENSE = 3;
  localparam int EIR_F_FAULT = 4;
  localparam int EIR_F_FH = 6;
  localparam int EIR_F_FL = 7;
  localparam int EIR_F_RDY = 8;
  localparam int EIR_F_ACT = 9;
  localparam logic [1:0] EIR_MODE_OFF = 2'h0;
  localparam logic [1:0] EIR_EOC_CODE = 2'h3;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [15:0] EIR_HIGH_RST = 16'hbfff;
  localparam logic [15:0] EIR_LOW_RST = 16'h0000;
  localparam logic [1:0] EIR_MODE_RST = 2'h0;
  localparam logic EIR_LATCH_RST = 1'b1;
  localparam logic EIR_SENSE_RST = 1'b0;
  localparam logic [1:0] EIR_FAULT_RST = 2'h0;

  // ****************************************
  // Interrupt status bits
  // ****************************************
  localparam int EIR_S_CONV = 0;
  localparam int EIR_S_HIGH = 1;
  localparam int EIR_S_LOW = 2;
  localparam int EIR_S_ALERT = 3;
  localparam int EIR_NSTS = 4;

endpackage

// ### eir_top.sv
// Purpose: Interrupt reporting with end-of-conversion signalling.
// Assumes: Link pins are asynchronous and sampled on pclk.
// Notes: Registers are reached over APB with zero wait states.
`timescale 1ns/1ps

// Notes on behaviour
// - Low limit top bits 11b select eoc.
// - Plain completion: ready set; pin active in eoc.
// - Eoc pin cleared by read, active-mode write, latched alert.
// - Latched high hit: high flag, pin, ready.
// - Latched low hit: low flag, pin, ready.
// - Latched read clears flags, ready, pin.
// - Shutdown write keeps ready; pin too, unless it leaves latched mode outside eoc.
// - Active-mode write clears ready; pin too in eoc.
// - Transparent high hit sets high, clears low.
// - Transparent low hit sets low, clears high.
// - Transparent read clears ready; pin only in eoc.
// - Eoc works with either comparison style.
// - Pin level follows state and sense.
// - Ready self-clears after config read.
// - Crossing needs programmed consecutive count.
module eir_top
  import eir_pkg::*;
#(
  parameter int RES_W = 16
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic link_clk,
  input wire logic conv_done,
  input wire logic [RES_W-1:0] conv_result,
  input wire logic alert_ack,
  output logic int_pin,
  output logic irq
);

  // ****************************************
  // Link synchronisers
  // ****************************************
  logic [2:0] clk_s_r;
  logic [1:0] done_s_r;
  logic [1:0] alrt_s_r;
  logic [RES_W-1:0] res_s1_r, res_s2_r;
  logic done_l_r, done_l_nxt;
  logic alrt_l_r, alrt_l_nxt;
  logic link_rise, conv_ev, alert_ev;

  // Two flops per pin; the third clock flop only feeds edge detection.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      clk_s_r <= 3'h0;
      done_s_r <= 2'h0;
      alrt_s_r <= 2'h0;
      res_s1_r <= '0;
      res_s2_r <= '0;
    end
    else
    begin
      clk_s_r <= {clk_s_r[1:0], link_clk};
      done_s_r <= {done_s_r[0], conv_done};
      alrt_s_r <= {alrt_s_r[0], alert_ack};
      res_s1_r <= conv_result;
      res_s2_r <= res_s1_r;
    end
  end

  // Pins count only at rising link clock edges, once per rising level.
  always_comb
  begin
    link_rise = clk_s_r[1] & ~clk_s_r[2];
    conv_ev = link_rise & done_s_r[1] & ~done_l_r;
    alert_ev = link_rise & alrt_s_r[1] & ~alrt_l_r;
    done_l_nxt = link_rise ? done_s_r[1] : done_l_r;
    alrt_l_nxt = link_rise ? alrt_s_r[1] : alrt_l_r;
  end

  // Registers the levels seen at the last link edge.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      done_l_r <= 1'b0;
      alrt_l_r <= 1'b0;
    end
    else
    begin
      done_l_r <= done_l_nxt;
      alrt_l_r <= alrt_l_nxt;
    end
  end

  // ****************************************
  // APB decode
  // ****************************************
  logic setup, acc, hit;
  logic acc_wr, acc_rd;
  logic cfg_rd, cfg_wr, sts_rd;

  // Zero wait states; unmapped addresses answer with an error.
  always_comb
  begin
    setup = psel & ~penable;
    acc = psel & penable;
    hit = (paddr == EIR_A_CFG) | (paddr == EIR_A_HIGH)
      | (paddr == EIR_A_LOW) | (paddr == EIR_A_STS)
      | (paddr == EIR_A_MASK) | (paddr == EIR_A_RES);
    acc_wr = acc & pwrite & hit;
    acc_rd = acc & ~pwrite & hit;
    cfg_rd = acc_rd & (paddr == EIR_A_CFG);
    cfg_wr = acc_wr & (paddr == EIR_A_CFG);
    sts_rd = acc_rd & (paddr == EIR_A_STS);
    pready = acc;
    pslverr = acc & ~hit;
  end

  // ****************************************
  // Reporting state
  // ****************************************
  logic [1:0] mode_r, mode_nxt;
  logic latch_r, latch_nxt;
  logic sense_r, sense_nxt;
  logic [1:0] fault_r, fault_nxt;
  logic [15:0] high_r, high_nxt;
  logic [15:0] low_r, low_nxt;
  logic [RES_W-1:0] res_r, res_nxt;
  logic fh_r, fh_nxt;
  logic fl_r, fl_nxt;
  logic rdy_r, rdy_nxt;
  logic act_r, act_nxt;
  logic pin_r, pin_nxt;
  logic [3:0] hcnt_r, hcnt_nxt;
  logic [3:0] lcnt_r, lcnt_nxt;
  logic [EIR_NSTS-1:0] sts_r, sts_nxt;
  logic [EIR_NSTS-1:0] mask_r, mask_nxt;
  logic [EIR_NSTS-1:0] sts_set;
  logic [31:0] rd_r, rd_nxt;
  logic [31:0] cfg_word;
  logic [3:0] need;
  logic eoc, above, below;
  logic hi_hit, lo_hit;

  // Computes every next value except read data: completion first, then access clears.
  always_comb
  begin
    mode_nxt = mode_r;
    latch_nxt = latch_r;
    sense_nxt = sense_r;
    fault_nxt = fault_r;
    high_nxt = high_r;
    low_nxt = low_r;
    res_nxt = res_r;
    fh_nxt = fh_r;
    fl_nxt = fl_r;
    rdy_nxt = rdy_r;
    act_nxt = act_r;
    hcnt_nxt = hcnt_r;
    lcnt_nxt = lcnt_r;
    mask_nxt = mask_r;
    sts_set = '0;
    eoc = low_r[15:14] == EIR_EOC_CODE;
    need = 4'h1 << fault_r;
    above = 16'(res_s2_r) > high_r;
    below = 16'(res_s2_r) < low_r;
    // Prior count against need minus one; a saturated count cannot wrap.
    hi_hit = above & (hcnt_r >= (need - 4'h1));
    lo_hit = below & (lcnt_r >= (need - 4'h1));
    if (conv_ev)
    begin
      res_nxt = res_s2_r;
      hcnt_nxt = above ? ((hcnt_r == 4'hf) ? hcnt_r : hcnt_r + 4'h1)
        : 4'h0;
      lcnt_nxt = below ? ((lcnt_r == 4'hf) ? lcnt_r : lcnt_r + 4'h1)
        : 4'h0;
      rdy_nxt = 1'b1;
      sts_set[EIR_S_CONV] = 1'b1;
      if (eoc)
        act_nxt = 1'b1;
      if (hi_hit)
      begin
        fh_nxt = 1'b1;
        act_nxt = 1'b1;
        sts_set[EIR_S_HIGH] = 1'b1;
        if (!latch_r)
          fl_nxt = 1'b0;
      end
      if (lo_hit)
      begin
        fl_nxt = 1'b1;
        sts_set[EIR_S_LOW] = 1'b1;
        if (!latch_r)
          fh_nxt = 1'b0;
        act_nxt = eoc | latch_r;
      end
    end
    if (cfg_rd)
    begin
      rdy_nxt = 1'b0;
      if (latch_r)
      begin
        fh_nxt = 1'b0;
        fl_nxt = 1'b0;
        act_nxt = 1'b0;
      end
      else if (eoc)
        act_nxt = 1'b0;
    end
    if (cfg_wr)
    begin
      mode_nxt = pwdata[EIR_F_MODE +: 2];
      latch_nxt = pwdata[EIR_F_LATCH];
      sense_nxt = pwdata[EIR_F_SENSE];
      fault_nxt = pwdata[EIR_F_FAULT +: 2];
      if (pwdata[EIR_F_MODE +: 2] != EIR_MODE_OFF)
      begin
        rdy_nxt = 1'b0;
        if (eoc)
          act_nxt = 1'b0;
      end
      if (latch_r && !pwdata[EIR_F_LATCH] && !eoc)
        act_nxt = 1'b0;
    end
    if (alert_ev && latch_r)
    begin
      act_nxt = 1'b0;
      sts_set[EIR_S_ALERT] = 1'b1;
    end
    if (acc_wr && paddr == EIR_A_HIGH)
      high_nxt = pwdata[15:0];
    if (acc_wr && paddr == EIR_A_LOW)
      low_nxt = pwdata[15:0];
    if (acc_wr && paddr == EIR_A_MASK)
      mask_nxt = pwdata[EIR_NSTS-1:0];
    // A new event wins over the clear from a status read.
    sts_nxt = (sts_rd ? '0 : sts_r) | sts_set;
    // Inactive level tracks the sense bit as well as the state.
    pin_nxt = act_nxt ? sense_nxt : ~sense_nxt;
  end

  // Read data is captured in the setup cycle, before side effects.
  always_comb
  begin
    cfg_word = '0;
    cfg_word[EIR_F_MODE +: 2] = mode_r;
    cfg_word[EIR_F_LATCH] = latch_r;
    cfg_word[EIR_F_SENSE] = sense_r;
    cfg_word[EIR_F_FAULT +: 2] = fault_r;
    cfg_word[EIR_F_FH] = fh_r;
    cfg_word[EIR_F_FL] = fl_r;
    cfg_word[EIR_F_RDY] = rdy_r;
    cfg_word[EIR_F_ACT] = act_r;
    rd_nxt = rd_r;
    if (setup && !pwrite)
    begin
      unique case (paddr)
        EIR_A_CFG: rd_nxt = cfg_word;
        EIR_A_HIGH: rd_nxt = {16'h0000, high_r};
        EIR_A_LOW: rd_nxt = {16'h0000, low_r};
        EIR_A_STS: rd_nxt = {28'h0000000, sts_r};
        EIR_A_MASK: rd_nxt = {28'h0000000, mask_r};
        EIR_A_RES: rd_nxt = 32'(res_r);
        default: rd_nxt = 32'h00000000;
      endcase
    end
  end

  // Registers the reporting state.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mode_r <= EIR_MODE_RST;
      latch_r <= EIR_LATCH_RST;
      sense_r <= EIR_SENSE_RST;
      fault_r <= EIR_FAULT_RST;
      high_r <= EIR_HIGH_RST;
      low_r <= EIR_LOW_RST;
      res_r <= '0;
      fh_r <= 1'b0;
      fl_r <= 1'b0;
      rdy_r <= 1'b0;
      act_r <= 1'b0;
      pin_r <= 1'b1;
      hcnt_r <= 4'h0;
      lcnt_r <= 4'h0;
      sts_r <= '0;
      mask_r <= '0;
      rd_r <= 32'h00000000;
    end
    else
    begin
      mode_r <= mode_nxt;
      latch_r <= latch_nxt;
      sense_r <= sense_nxt;
      fault_r <= fault_nxt;
      high_r <= high_nxt;
      low_r <= low_nxt;
      res_r <= res_nxt;
      fh_r <= fh_nxt;
      fl_r <= fl_nxt;
      rdy_r <= rdy_nxt;
      act_r <= act_nxt;
      pin_r <= pin_nxt;
      hcnt_r <= hcnt_nxt;
      lcnt_r <= lcnt_nxt;
      sts_r <= sts_nxt;
      mask_r <= mask_nxt;
      rd_r <= rd_nxt;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************

  // Pin and read data come from flops; irq is a masked level.
  always_comb
  begin
    int_pin = pin_r;
    prdata = rd_r;
    irq = |(sts_r & mask_r);
  end

endmodule

// ### eir_top_chk_properties.sv
// Purpose: Port checks for the eoc interrupt block.
// Assumes: Zero wait APB; inactive pin level is the inverse of sense.
// Notes: Sense and eoc selection are shadowed from bus writes.
`timescale 1ns/1ps
module eir_top_chk
  import eir_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic int_pin
);
  // ****************************************
  // Shadow of sense and eoc selection
  // ****************************************
  logic acc;
  logic eoc_r, eoc_nxt, sense_r, sense_nxt;
  assign acc = psel && penable;
  // Next values follow the writes that the bus completes.
  always_comb
  begin
    eoc_nxt = eoc_r;
    sense_nxt = sense_r;
    if (acc && pwrite && paddr == EIR_A_LOW)
      eoc_nxt = pwdata[15:14] == EIR_EOC_CODE;
    if (acc && pwrite && paddr == EIR_A_CFG)
      sense_nxt = pwdata[EIR_F_SENSE];
  end
  // Shadow registers start at the reset values.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      eoc_r <= 1'b0;
      sense_r <= EIR_SENSE_RST;
    end
    else
    begin
      eoc_r <= eoc_nxt;
      sense_r <= sense_nxt;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_cfg_rd;
    acc && !pwrite && paddr == EIR_A_CFG;
  endsequence
  sequence s_cfg_run;
    acc && pwrite && paddr == EIR_A_CFG && pwdata[1:0] != EIR_MODE_OFF;
  endsequence
  property p_ready;
    pready == (psel && penable);
  endproperty
  property p_unmapped;
    acc && !pwrite && paddr > EIR_A_RES |-> pslverr && prdata == 32'h0;
  endproperty
  property p_mapped;
    acc && paddr == EIR_A_CFG |-> !pslverr;
  endproperty
  property p_idle_err;
    !acc |-> !pslverr;
  endproperty
  property p_hold;
    !(psel && !penable && !pwrite) |=> $stable(prdata);
  endproperty
  property p_upper;
    s_cfg_rd |-> prdata[31:10] == 22'h0;
  endproperty
  property p_rd_pin;
    eoc_r ##0 s_cfg_rd |=> int_pin == !sense_r;
  endproperty
  property p_wr_pin;
    eoc_r ##0 s_cfg_run |=> int_pin == !sense_r;
  endproperty
  a_ready: assert property (p_ready) else $error("pready wrong");
  a_unmapped: assert property (p_unmapped) else $error("unmapped wrong");
  a_mapped: assert property (p_mapped) else $error("mapped refused");
  a_idle_err: assert property (p_idle_err) else $error("idle error");
  a_hold: assert property (p_hold) else $error("read data moved");
  a_upper: assert property (p_upper) else $error("upper bits set");
  a_rd_pin: assert property (p_rd_pin) else $error("pin kept");
  a_wr_pin: assert property (p_wr_pin) else $error("pin kept");
endmodule
bind eir_top eir_top_chk i_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .int_pin(int_pin));

// ### eir_far_end.sv
// Purpose: Conversion source and alert responder on the link side.
// Assumes: Link clock runs free at 160 ns.
// Notes: Result lines show the inverse once their hold has run out.
`timescale 1ns/1ps
module eir_far_end
(
  output logic link_clk,
  output logic conv_done,
  output logic [15:0] conv_result,
  output logic alert_ack
);
  // Link clock starts off the system clock phase.
  initial
  begin
    link_clk = 1'b0;
    conv_done = 1'b0;
    conv_result = 16'h5a5a;
    alert_ack = 1'b0;
    #13;
    forever #80 link_clk = ~link_clk;
  end
  task convert(input logic [15:0] v);
    @(negedge link_clk);
    conv_result = v;
    conv_done = 1'b1;
    @(negedge link_clk);
    conv_done = 1'b0;
    @(negedge link_clk);
    conv_result = ~v;
  endtask
  task alert();
    @(negedge link_clk);
    alert_ack = 1'b1;
    @(negedge link_clk);
    alert_ack = 1'b0;
  endtask
endmodule

// ### test_eoc_interrupt_reporting.sv
// Purpose: Self-checking bench for the eoc interrupt block.
// Assumes: Pin events settle within eight clocks of a link edge.
// Notes: Sense starts at 0, so an active pin reads 0.
`timescale 1ns/1ps
module test_eoc_interrupt_reporting
  import eir_pkg::*;
;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rdat;
  logic pready, pslverr, link_clk, conv_done, alert_ack, int_pin, irq, serr;
  logic [15:0] conv_result;
  int error_cnt = 0, num_checks = 0;
  always #10 pclk = ~pclk;
  eir_top #(.RES_W(16)) i_eir_top (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .link_clk(link_clk), .conv_done(conv_done), .conv_result(conv_result),
    .alert_ack(alert_ack), .int_pin(int_pin), .irq(irq));
  eir_far_end i_eir_far_end (.link_clk(link_clk), .conv_done(conv_done),
    .conv_result(conv_result), .alert_ack(alert_ack));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      $display("Error at %0t: got %h expected %h", $time, got, exp);
      error_cnt++;
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdat = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask
  task automatic conv(input logic [15:0] v);
    i_eir_far_end.convert(v);
    repeat (8) @(posedge pclk);
    #1;
  endtask
  // Alert response, then time for the pin to settle off the clock edge.
  task automatic alrt();
    i_eir_far_end.alert();
    repeat (8) @(posedge pclk);
    #1;
  endtask
  task automatic t_latched();
    apb(0, EIR_A_HIGH, 0);
    chk(rdat, 32'hbfff);
    apb(1, EIR_A_LOW, 32'hc000);
    apb(1, EIR_A_CFG, 32'h16);
    conv(16'h0100);
    chk(int_pin, 1'b0);
    apb(0, EIR_A_CFG, 0);
    chk(rdat[9:6], 4'hc);
    apb(0, EIR_A_CFG, 0);
    chk(rdat[8], 1'b0);
    conv(16'h0100);
    alrt();
    chk(int_pin, 1'b1);
    apb(0, EIR_A_STS, 0);
    chk(rdat[3:0], 4'hd);
    apb(0, EIR_A_CFG, 0);
    chk(rdat[9:6], 4'h6);
    apb(0, EIR_A_CFG, 0);
    chk(rdat[9:6], 4'h0);
    conv(16'hffff);
    conv(16'hffff);
    apb(0, EIR_A_CFG, 0);
    chk(rdat[9:6], 4'hd);
    conv(16'hffff);
    apb(1, EIR_A_CFG, 32'h14);
    chk(int_pin, 1'b0);
    apb(1, EIR_A_CFG, 32'h16);
    apb(0, EIR_A_CFG, 0);
    chk(rdat[9:6], 4'h1);
    conv(16'hffff);
    apb(1, EIR_A_LOW, 0);
    apb(1, EIR_A_CFG, 32'h12);
    chk(int_pin, 1'b1);
  endtask
  task automatic t_transp();
    apb(1, EIR_A_LOW, 32'hc000);
    apb(1, EIR_A_CFG, 32'h02);
    conv(16'hffff);
    alrt();
    chk(int_pin, 1'b0);
    apb(0, EIR_A_CFG, 0);
    chk(rdat[9:6], 4'hd);
    conv(16'h0001);
    apb(0, EIR_A_CFG, 0);
    chk(rdat[9:6], 4'he);
    chk(int_pin, 1'b1);
    apb(1, EIR_A_CFG, 32'h0a);
    chk(int_pin, 1'b0);
    conv(16'h0001);
    chk(int_pin, 1'b1);
  endtask
  // Eight consecutive lows needed, then a long run past counter saturation.
  task automatic t_fault();
    apb(1, EIR_A_LOW, 32'h0010);
    apb(1, EIR_A_CFG, 32'h36);
    apb(0, EIR_A_CFG, 0);
    conv(16'h1000);
    repeat (7) conv(16'h0001);
    apb(0, EIR_A_CFG, 0);
    chk(rdat[7], 1'b0);
    conv(16'h0001);
    apb(0, EIR_A_CFG, 0);
    chk(rdat[7], 1'b1);
    apb(1, EIR_A_CFG, 32'h06);
    repeat (9)
    begin
      conv(16'h0001);
      apb(0, EIR_A_CFG, 0);
      chk(rdat[7], 1'b1);
    end
  endtask
  task automatic t_irq();
    apb(1, EIR_A_MASK, 32'h1);
    apb(0, EIR_A_STS, 0);
    conv(16'h0001);
    chk(irq, 1'b1);
    apb(0, EIR_A_RES, 0);
    chk(rdat, 32'h00000001);
    apb(0, EIR_A_STS, 0);
    chk(rdat[0], 1'b1);
    chk(irq, 1'b0);
    apb(1, EIR_A_MASK, 0);
    conv(16'h0001);
    chk(irq, 1'b0);
    apb(0, 8'h40, 0);
    chk({serr, rdat[30:0]}, 32'h80000000);
  endtask
  task automatic final_report();
    if (error_cnt == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Main sequence holds reset for 20 clocks, then runs each scenario.
  initial
  begin
    repeat (20) @(posedge pclk);
    chk(int_pin, 1'b1);
    presetn <= 1'b1;
    t_latched();
    t_transp();
    t_irq();
    t_fault();
    final_report();
  end
  // Watchdog ends a hung run.
  initial
  begin
    #1000000;
    error_cnt++;
    final_report();
  end
endmodule
